// ==== design/wdg_cfg.svh ====
// watchdog interval timer constants: offsets, fields, reset values, timing
`ifndef WDG_CFG_SVH
`define WDG_CFG_SVH
// register offsets are word indices; the bus address is four times these
`define WDG_OFF_ENABLE 12'h000
`define WDG_OFF_FLAG 12'h002
`define WDG_OFF_CONTROL 12'h120
`define WDG_OFF_STATUS 12'h124
`define WDG_KEY_WRITE 8'h5A
`define WDG_KEY_READ 8'h69
`define WDG_CTRL_RESET 8'h00
`define WDG_BIT_HOLD 7
`define WDG_BIT_NMI_EDGE 6
`define WDG_BIT_NMI_SEL 5
`define WDG_BIT_MODE 4
`define WDG_BIT_CLEAR 3
`define WDG_BIT_CLK_SEL 2
`define WDG_TAP_IS0 15
`define WDG_TAP_IS1 13
`define WDG_TAP_IS2 9
`define WDG_TAP_IS3 6
`define WDG_POWERUP_MS 32
`define WDG_MCLK_MHZ 40
`define WDG_FAIL_TIMEOUT 16'h0100
`endif

// ==== design/wdg_pkg.sv ====
// watchdog interval timer types
package wdg_pkg;
  typedef enum logic [2:0] {
    WDG_IDLE = 3'b001,
    WDG_SETUP = 3'b010,
    WDG_ACCESS = 3'b100
  } wdg_bus_state_t;
  typedef enum logic [1:0] {
    WDG_SRC_SUB = 2'b01,
    WDG_SRC_MAIN = 2'b10
  } wdg_src_t;
endpackage : wdg_pkg

// ==== design/wdg_edge.sv ====
// rising edge detector for a synchronous clock-enable input
`timescale 1ns/1ps
module wdg_edge (
  input wire logic mclk,
  input wire logic srst,
  input wire logic level,
  output logic pulse
);
  logic last;
  // remember previous level
  always_ff @(posedge mclk) begin
    if (srst) begin
      last <= 1'b0;
    end else begin
      last <= level;
    end
  end
  assign pulse = level & ~last;
endmodule : wdg_edge

// ==== design/wdg_counter.sv ====
// 16-bit guard counter with hold, clear and tap selection
`timescale 1ns/1ps
`include "wdg_cfg.svh"
module wdg_counter (
  input wire logic mclk,
  input wire logic srst,
  input wire logic tick,
  input wire logic hold,
  input wire logic clear,
  input wire logic [1:0] interval_select,
  output logic [15:0] guard_counter,
  output logic expire
);
  // pick the tap bit for the chosen interval
  function automatic logic tap_of(input logic [1:0] sel,
                                  input logic [15:0] cnt);
    case (sel)
      2'b00: tap_of = cnt[`WDG_TAP_IS0];
      2'b01: tap_of = cnt[`WDG_TAP_IS1];
      2'b10: tap_of = cnt[`WDG_TAP_IS2];
      default: tap_of = cnt[`WDG_TAP_IS3];
    endcase
  endfunction : tap_of
  logic tap_now;
  logic tap_last;
  assign tap_now = tap_of(interval_select, guard_counter);
  // up-counter; clear beats hold, hold beats tick
  always_ff @(posedge mclk) begin
    if (srst || clear) begin
      guard_counter <= 16'h0000;
    end else if (tick && !hold) begin
      guard_counter <= guard_counter + 16'h0001;
    end
  end
  // expiry is the chosen tap rising
  always_ff @(posedge mclk) begin
    if (srst || clear) begin
      tap_last <= 1'b0;
    end else begin
      tap_last <= tap_now;
    end
  end
  assign expire = tap_now & ~tap_last;
endmodule : wdg_counter

// ==== design/wdg_timer.sv ====
// watchdog and interval timer with apb register slave
//
// Operation
// - control writes need key 5Ah, else clear
// - control reads return 69h upper byte
// - hidden 16-bit up-counter, control only
// - counter clocked by auxiliary or sub-main
// - starts watchdog mode, ~32 ms, oscillator
// - watchdog expiry raises power-up clear
// - clear restores defaults, pin reset function
// - mode bit one selects interval mode
// - interval expiry sets flag, no reset
// - interrupt needs flag, enable, global enable
// - flag clears on service or software
// - interval interrupt has its own vector
// - flag and enable sit at bit 0
// - flag survives watchdog-caused reset
// - unheld watchdog mode keeps selected clock running
// - failed clock falls back to main
// - no fail-safe in interval mode
// - hold freezes the counter
// - exactly four intervals, both modes
// - taps divide 32768, 8192, 512, 64
// - clear bit zeroes counter, reads zero
// - select 0 sub-main, 1 auxiliary
// - pin field 0 reset, 1 nmi
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "wdg_cfg.svh"
module wdg_timer (
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic aux_clock_tick,
  input wire logic sub_main_clock_tick,
  input wire logic oscillator_clock_tick,
  input wire logic main_clock_tick,
  input wire logic aux_clock_ok,
  input wire logic sub_main_clock_ok,
  input wire logic global_irq_enable,
  input wire logic irq_serviced,
  output logic power_up_clear,
  output logic interval_irq,
  output logic reset_vector_flag,
  output logic pin_nmi_select,
  output logic pin_nmi_edge,
  output logic keep_aux_clock,
  output logic keep_sub_main_clock
);
  ////////////////////////////////////////////////////////////////////
  // address decode: one word per register, byte address is 4 x index
  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] off);
    hit = (a == {off[9:0], 2'b00});
  endfunction : hit

  logic [7:0] guard_control_word;
  logic sfr_flag_reg_one;
  logic sfr_enable_reg_one;
  logic booting;
  logic guard_hold;
  logic guard_mode_select;
  logic guard_clock_select;
  logic [1:0] guard_interval_select;
  logic wr_take;
  logic rd_take;
  logic key_bad;
  logic ctl_write;
  logic known;
  logic guard_count_clear;
  logic tick_level;
  logic tick_pulse;
  logic expire;
  logic [15:0] guard_counter;
  logic src_failed;
  logic fail_state;
  logic [15:0] fail_count;
  logic next_fail_state;
  wdg_pkg::wdg_src_t src_now;
  wdg_pkg::wdg_bus_state_t bus_state;

  assign guard_hold = guard_control_word[`WDG_BIT_HOLD];
  assign guard_mode_select = guard_control_word[`WDG_BIT_MODE];
  assign guard_clock_select = guard_control_word[`WDG_BIT_CLK_SEL];
  assign guard_interval_select = guard_control_word[1:0];
  assign pin_nmi_select = guard_control_word[`WDG_BIT_NMI_SEL];
  assign pin_nmi_edge = guard_control_word[`WDG_BIT_NMI_EDGE];

  ////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, unmapped addresses error
  assign known = hit(paddr, `WDG_OFF_CONTROL) ||
                 hit(paddr, `WDG_OFF_FLAG) ||
                 hit(paddr, `WDG_OFF_ENABLE) ||
                 hit(paddr, `WDG_OFF_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~known;
  assign wr_take = psel & penable & pwrite & known;
  assign rd_take = psel & penable & ~pwrite & known;
  assign ctl_write = wr_take && hit(paddr, `WDG_OFF_CONTROL);
  // a control write with the wrong key is a violation
  assign key_bad = ctl_write && (pwdata[15:8] != `WDG_KEY_WRITE);
  assign guard_count_clear = ctl_write && !key_bad &&
                             pwdata[`WDG_BIT_CLEAR];

  // bus phase tracker, used by the cover points only
  always_ff @(posedge mclk) begin
    if (srst) begin
      bus_state <= wdg_pkg::WDG_IDLE;
    end else begin
      case (bus_state)
        wdg_pkg::WDG_IDLE:
          bus_state <= psel ? wdg_pkg::WDG_SETUP : wdg_pkg::WDG_IDLE;
        wdg_pkg::WDG_SETUP: bus_state <= wdg_pkg::WDG_ACCESS;
        wdg_pkg::WDG_ACCESS:
          bus_state <= psel && !penable ? wdg_pkg::WDG_SETUP
                                        : wdg_pkg::WDG_IDLE;
        default: bus_state <= wdg_pkg::WDG_IDLE;
      endcase
    end
  end

  // read mux; registered data
  always_ff @(posedge mclk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (hit(paddr, `WDG_OFF_CONTROL)) begin
        prdata <= {16'h0000, `WDG_KEY_READ,
                   guard_control_word & 8'hF7};
      end else if (hit(paddr, `WDG_OFF_FLAG)) begin
        prdata <= {31'h0, sfr_flag_reg_one};
      end else if (hit(paddr, `WDG_OFF_ENABLE)) begin
        prdata <= {31'h0, sfr_enable_reg_one};
      end else if (hit(paddr, `WDG_OFF_STATUS)) begin
        prdata <= {29'h0, fail_state, booting, guard_mode_select};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control word; power-up clear restores defaults
  // the clear bit is never stored, so it reads zero
  always_ff @(posedge mclk) begin
    if (srst || power_up_clear) begin
      guard_control_word <= `WDG_CTRL_RESET;
    end else if (ctl_write && !key_bad) begin
      guard_control_word <= pwdata[7:0] & 8'hF7;
    end
  end

  // boot phase: oscillator clock until first good write
  always_ff @(posedge mclk) begin
    if (srst || power_up_clear) begin
      booting <= 1'b1;
    end else if (ctl_write && !key_bad) begin
      booting <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // clock source and fail-safe
  // a failed source in watchdog mode swaps to main clock
  assign src_failed = guard_clock_select ? !aux_clock_ok
                                         : !sub_main_clock_ok;
  assign next_fail_state = !guard_mode_select && !booting &&
                           src_failed;
  always_ff @(posedge mclk) begin
    if (srst) begin
      fail_state <= 1'b0;
      fail_count <= 16'h0000;
    end else begin
      fail_state <= next_fail_state;
      fail_count <= next_fail_state ? fail_count + 16'h0001 : 16'h0000;
    end
  end
  assign src_now = fail_state ? wdg_pkg::WDG_SRC_MAIN
                              : wdg_pkg::WDG_SRC_SUB;

  // tick selection: aux when select is 1, sub-main when 0
  always_comb begin
    if (booting) begin
      tick_level = oscillator_clock_tick;
    end else if (src_now == wdg_pkg::WDG_SRC_MAIN) begin
      tick_level = main_clock_tick;
    end else if (guard_clock_select) begin
      tick_level = aux_clock_tick;
    end else begin
      tick_level = sub_main_clock_tick;
    end
  end

  // the selected clock stays requested in unheld watchdog mode only
  assign keep_aux_clock = !guard_mode_select && !guard_hold &&
                          guard_clock_select;
  assign keep_sub_main_clock = !guard_mode_select && !guard_hold &&
                               !guard_clock_select;

  wdg_edge u_edge (
    .mclk(mclk),
    .srst(srst),
    .level(tick_level),
    .pulse(tick_pulse)
  );

  // hidden counter; only control bits steer it
  wdg_counter u_counter (
    .mclk(mclk),
    .srst(srst || power_up_clear),
    .tick(tick_pulse),
    .hold(guard_hold),
    .clear(guard_count_clear),
    .interval_select(guard_interval_select),
    .guard_counter(guard_counter),
    .expire(expire)
  );

  ////////////////////////////////////////////////////////////////////
  // power-up clear pulse: watchdog expiry or key violation
  always_ff @(posedge mclk) begin
    if (srst) begin
      power_up_clear <= 1'b0;
    end else begin
      power_up_clear <= key_bad || (expire && !guard_mode_select);
    end
  end

  // flag: set wins over clear; survives power-up clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      sfr_flag_reg_one <= 1'b0;
    end else if (key_bad || expire) begin
      sfr_flag_reg_one <= 1'b1;
    end else if (guard_mode_select && irq_serviced) begin
      sfr_flag_reg_one <= 1'b0;
    end else if (wr_take && hit(paddr, `WDG_OFF_FLAG)) begin
      sfr_flag_reg_one <= pwdata[0];
    end
  end

  // enable bit is cleared by power-up clear, untouched by expiry
  always_ff @(posedge mclk) begin
    if (srst || power_up_clear) begin
      sfr_enable_reg_one <= 1'b0;
    end else if (wr_take && hit(paddr, `WDG_OFF_ENABLE)) begin
      sfr_enable_reg_one <= pwdata[0];
    end
  end

  // separate vectors: interrupt line vs reset-cause flag
  assign interval_irq = guard_mode_select && sfr_flag_reg_one &&
                        sfr_enable_reg_one && global_irq_enable;
  assign reset_vector_flag = !guard_mode_select &&
                             sfr_flag_reg_one;

  ////////////////////////////////////////////////////////////////////
  // assertions
  AST_KEY_PUC: assert property (@(posedge mclk) disable iff (srst)
    key_bad |=> power_up_clear)
    else $error("bad key did not raise clear");
  AST_READ_KEY: assert property (@(posedge mclk) disable iff (srst)
    psel && !penable && !pwrite && hit(paddr, `WDG_OFF_CONTROL)
    |=> prdata[15:8] == 8'h69 && prdata[3] == 1'b0)
    else $error("control read key wrong");
  AST_WD_EXPIRE: assert property (@(posedge mclk) disable iff (srst)
    expire && !guard_mode_select |=> power_up_clear)
    else $error("watchdog expiry missed clear");
  AST_PUC_DEFAULT: assert property (@(posedge mclk) disable iff (srst)
    power_up_clear |=> guard_control_word == 8'h00 && booting
    && !pin_nmi_select)
    else $error("clear did not restore defaults");
  AST_IV_NO_PUC: assert property (@(posedge mclk) disable iff (srst)
    expire && guard_mode_select && !key_bad
    |=> !power_up_clear && sfr_flag_reg_one)
    else $error("interval expiry wrong");
  AST_IRQ: assert property (@(posedge mclk) disable iff (srst)
    interval_irq |-> sfr_enable_reg_one && global_irq_enable)
    else $error("irq without enables");
  AST_FLAG_KEEP: assert property (@(posedge mclk) disable iff (srst)
    power_up_clear |-> sfr_flag_reg_one)
    else $error("flag lost on watchdog reset");
  AST_HOLD: assert property (@(posedge mclk) disable iff (srst)
    guard_hold && !guard_count_clear && !power_up_clear
    |=> guard_counter == $past(guard_counter))
    else $error("counter moved in hold");
  AST_CLEAR: assert property (@(posedge mclk) disable iff (srst)
    guard_count_clear |=> guard_counter == 16'h0000)
    else $error("counter not cleared");
  AST_NO_FAILSAFE: assert property (@(posedge mclk) disable iff (srst)
    guard_mode_select |=> !fail_state)
    else $error("fail-safe in interval mode");
  // counter, key and control checks
  // a tick outside hold, clear and power-up clear advances by exactly one
  AST_COUNT_STEP: assert property (@(posedge mclk) disable iff (srst)
    tick_pulse && !guard_hold && !guard_count_clear && !power_up_clear
    |=> guard_counter == $past(guard_counter) + 16'h0001)
    else $error("counter did not step by one");
  // a refused write must leave the stored control bits alone
  AST_BAD_KEY_KEEP: assert property (@(posedge mclk) disable iff (srst)
    key_bad && !power_up_clear
    |=> guard_control_word == $past(guard_control_word))
    else $error("bad key changed control");
  AST_MODE_WRITE: assert property (@(posedge mclk) disable iff (srst)
    ctl_write && !key_bad && pwdata[`WDG_BIT_MODE] && !power_up_clear
    |=> guard_mode_select)
    else $error("mode bit not taken");
  // flag, enable and clock checks
  AST_FLAG_SET: assert property (@(posedge mclk) disable iff (srst)
    expire |=> sfr_flag_reg_one)
    else $error("expiry did not set flag");
  AST_SERVICE_CLR: assert property (@(posedge mclk) disable iff (srst)
    guard_mode_select && irq_serviced && !key_bad && !expire
    |=> !sfr_flag_reg_one)
    else $error("service did not clear flag");
  // expiry in interval mode must not touch the enable bit
  AST_ENABLE_KEEP: assert property (@(posedge mclk) disable iff (srst)
    expire && guard_mode_select && !power_up_clear
    && !(wr_take && hit(paddr, `WDG_OFF_ENABLE))
    |=> sfr_enable_reg_one == $past(sfr_enable_reg_one))
    else $error("expiry changed enable");
  AST_FAILSAFE_SET: assert property (@(posedge mclk) disable iff (srst)
    !guard_mode_select && !booting && src_failed |=> fail_state)
    else $error("dead source not replaced");
  // exactly one source stays requested while the watchdog runs
  AST_KEEP_CLK: assert property (@(posedge mclk) disable iff (srst)
    !guard_mode_select && !guard_hold
    |-> keep_aux_clock != keep_sub_main_clock)
    else $error("watchdog clock request wrong");
  COV_KEY: cover property (@(posedge mclk) key_bad);
  COV_WD: cover property (@(posedge mclk) expire && !guard_mode_select);
  COV_IRQ: cover property (@(posedge mclk) interval_irq);
  COV_FAIL: cover property (@(posedge mclk) fail_state && fail_count > 1);
  COV_BUS: cover property (@(posedge mclk)
    bus_state == wdg_pkg::WDG_ACCESS);
endmodule : wdg_timer

// ==== dv/wdg_clock_model.sv ====
// clock system model: tick levels for the four counter clock sources
`timescale 1ns/1ps
module wdg_clock_model (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [3:0] run,
  output logic aux_clock_tick,
  output logic sub_main_clock_tick,
  output logic oscillator_clock_tick,
  output logic main_clock_tick
);
  logic [1:0] phase;
  // two mclk high, two low; a stopped source stands low, never mid-level
  always_ff @(posedge mclk) begin
    if (srst || run == 4'h0) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end
  // one shared phase keeps every source in the same known rhythm
  assign aux_clock_tick = run[0] & phase[1];
  assign sub_main_clock_tick = run[1] & phase[1];
  assign oscillator_clock_tick = run[2] & phase[1];
  assign main_clock_tick = run[3] & phase[1];
endmodule : wdg_clock_model

// ==== dv/watchdog_interval_timer_tb_top.sv ====
// self-checking bench for the watchdog interval timer
`timescale 1ns/1ps
`include "wdg_cfg.svh"
module watchdog_interval_timer_tb_top;
  logic mclk, srst, psel, penable, pwrite, pready, pslverr, err;
  logic irq_on, serviced, aux_ok, sub_ok, pup, irq, rvf, nmi_sel, keep_aux;
  logic nmi_edge, keep_sub;
  logic aux_t, sub_t, osc_t, main_t;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] run;
  logic [7:0] lo, key;
  int n_mismatch, compares, pup_count;
  ////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // count the one-cycle system reset requests
  always @(posedge mclk) begin
    if (pup === 1'b1) pup_count++;
  end
  wdg_clock_model clocks (.mclk(mclk), .srst(srst), .run(run),
    .aux_clock_tick(aux_t), .sub_main_clock_tick(sub_t),
    .oscillator_clock_tick(osc_t), .main_clock_tick(main_t));
  wdg_timer DUT (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .aux_clock_tick(aux_t), .sub_main_clock_tick(sub_t),
    .oscillator_clock_tick(osc_t), .main_clock_tick(main_t),
    .aux_clock_ok(aux_ok), .sub_main_clock_ok(sub_ok),
    .global_irq_enable(irq_on), .irq_serviced(serviced),
    .power_up_clear(pup), .interval_irq(irq), .reset_vector_flag(rvf),
    .pin_nmi_select(nmi_sel), .pin_nmi_edge(nmi_edge),
    .keep_aux_clock(keep_aux), .keep_sub_main_clock(keep_sub));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic give_verdict;
    $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  // whole-word apb transfer to register index a; a missing pready ends the run
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {a[9:0], 2'b00};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_mismatch++;
      give_verdict();
    end
  endtask : apb
  task automatic ctrl(input logic [7:0] v);
    apb(1'b1, `WDG_OFF_CONTROL, {16'h0000, 8'h5A, v});
  endtask : ctrl
  // n rising edges of the sources in mask m, then let expiry settle
  task automatic ticks(input logic [3:0] m, input int n);
    run <= m;
    repeat (4 * n) @(posedge mclk);
    run <= 4'h0;
    repeat (6) @(posedge mclk);
  endtask : ticks
  task automatic expect_flag(input logic want);
    apb(1'b0, `WDG_OFF_FLAG, 32'h0);
    check({31'h0, rd[0]}, {31'h0, want});
  endtask : expect_flag
  // control reads: fixed upper byte, clear bit always low
  function automatic logic [31:0] exp_ctrl(input logic [7:0] v);
    return {16'h0000, 8'h69, v & 8'hF7};
  endfunction : exp_ctrl
  function automatic int tap_len(input int c);
    return (c == 1) ? 8192 : (c == 2) ? 512 : 64;
  endfunction : tap_len
  ////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    run = 4'h0;
    irq_on = 1'b0;
    serviced = 1'b0;
    aux_ok = 1'b1;
    sub_ok = 1'b1;
    n_mismatch = 0;
    compares = 0;
    pup_count = 0;
    void'($urandom(75));
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    apb(1'b0, `WDG_OFF_CONTROL, 32'h0);
    check(rd, exp_ctrl(8'h00));
    apb(1'b0, `WDG_OFF_STATUS, 32'h0);
    check(rd & 32'h3, 32'h2);
    apb(1'b0, 12'h03F, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("test reset done");
    // wrong key with random payload
    key = 8'($urandom);
    if (key == 8'h5A) key = 8'hA5;
    apb(1'b1, `WDG_OFF_CONTROL, {16'h0000, key, 8'($urandom)});
    repeat (3) @(posedge mclk);
    check(32'(pup_count), 32'd1);
    check({31'h0, rvf}, 32'h1);
    expect_flag(1'b1);
    apb(1'b1, `WDG_OFF_FLAG, 32'h0);
    $display("test key done");
    // interval mode, auxiliary source, each short interval at its edge
    apb(1'b1, `WDG_OFF_ENABLE, 32'h1);
    irq_on <= 1'b1;
    for (int c = 1; c < 4; c++) begin
      lo = 8'h1C | 8'(c);
      ctrl(lo);
      apb(1'b0, `WDG_OFF_CONTROL, 32'h0);
      check(rd, exp_ctrl(lo));
      ticks(4'h1, tap_len(c) - 1);
      expect_flag(1'b0);
      ticks(4'h1, 1);
      expect_flag(1'b1);
      check({31'h0, irq}, 32'h1);
      check(32'(pup_count), 32'd1);
      apb(1'b1, `WDG_OFF_FLAG, 32'h0);
      expect_flag(1'b0);
    end
    ctrl(8'h1C);
    ticks(4'h1, 1024);
    expect_flag(1'b0);
    ctrl(8'h9F);
    ticks(4'h1, 128);
    expect_flag(1'b0);
    $display("test intervals done");
    // service clears the flag; global enable gates the request
    ctrl(8'h1F);
    ticks(4'h1, 64);
    irq_on <= 1'b0;
    repeat (2) @(posedge mclk);
    check({31'h0, irq}, 32'h0);
    serviced <= 1'b1;
    @(posedge mclk);
    serviced <= 1'b0;
    expect_flag(1'b0);
    // sub-main select ignores auxiliary ticks
    ctrl(8'h9B);
    ctrl(8'h1B);
    ticks(4'h1, 64);
    expect_flag(1'b0);
    ticks(4'h2, 64);
    expect_flag(1'b1);
    apb(1'b1, `WDG_OFF_FLAG, 32'h0);
    $display("test service and select done");
    // dead sub-main clock: no fallback in interval mode, fallback otherwise
    sub_ok <= 1'b0;
    ctrl(8'h1B);
    ticks(4'h8, 64);
    expect_flag(1'b0);
    ctrl(8'h0B);
    ticks(4'h8, 64);
    check(32'(pup_count), 32'd2);
    expect_flag(1'b1);
    apb(1'b0, `WDG_OFF_CONTROL, 32'h0);
    check(rd, exp_ctrl(8'h00));
    sub_ok <= 1'b1;
    apb(1'b1, `WDG_OFF_FLAG, 32'h0);
    $display("test fail-safe done");
    // watchdog expiry with the pin in its interrupt function
    ctrl(8'h6F);
    @(posedge mclk);
    check({31'h0, nmi_sel}, 32'h1);
    check({31'h0, nmi_edge}, 32'h1);
    check({31'h0, keep_aux}, 32'h1);
    check({31'h0, keep_sub}, 32'h0);
    ticks(4'h1, 63);
    check(32'(pup_count), 32'd2);
    ticks(4'h1, 1);
    check(32'(pup_count), 32'd3);
    check({31'h0, nmi_sel}, 32'h0);
    check({31'h0, nmi_edge}, 32'h0);
    $display("test watchdog done");
    give_verdict();
  end
endmodule : watchdog_interval_timer_tb_top
